/* File: common/asc_pkg.sv */
// Package of constants for the asynchronous SRAM host controller.
// Assumes a single 50 MHz clock; all pin timings are counted in whole cycles.
package asc_pkg;
    // ----------------------------------------
    // Array shape
    // ----------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    // ----------------------------------------
    // Timing, in ns, and derived cycle counts
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int ACCESS_NS = 35;
    localparam int WRITE_PULSE_NS = 25;
    localparam int DATA_SETUP_NS = 15;
    localparam int OUT_OFF_NS = 15;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFF_CYC = (OUT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ASC_IDLE,
        ASC_RD_SEL,
        ASC_RD_WAIT,
        ASC_WR_SEL,
        ASC_WR_PULSE,
        ASC_RECOVER
    } asc_state_e;
endpackage : asc_pkg

/* File: common/asc_tick_if.sv */
// Interface between the sequencer and its cycle timer.
// Assumes both ends share the one clock of the controller.
`timescale 1ns/100ps
interface asc_tick_if;
    logic load;
    logic [asc_pkg::CNT_W-1:0] count;
    logic done;
    modport master (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface : asc_tick_if

/* File: verilog/asc_timer.sv */
// Down-counting cycle timer for the SRAM sequencer.
// Load may be high on consecutive cycles, the last count loaded wins; done stays high while the count is zero.
`timescale 1ns/100ps
module asc_timer (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Sequencer side
    asc_tick_if.timer tk
);
    logic [asc_pkg::CNT_W-1:0] cnt_r;
    logic [asc_pkg::CNT_W-1:0] cnt_nxt;
    assign cnt_nxt = tk.load ? tk.count : (cnt_r == asc_pkg::CNT_ZERO ? cnt_r : cnt_r - asc_pkg::CNT_ONE);
    // Done must not look at load: the sequencer decodes load from done.
    assign tk.done = (cnt_r == asc_pkg::CNT_ZERO);
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt_r <= asc_pkg::CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : asc_timer

/* File: verilog/asc_host.sv */
// Host controller for an asynchronous 32K x 8 static RAM.
// Assumes the RAM pins are wired straight to the ports and pin inputs are synchronous to CLK.
`timescale 1ns/100ps
// Summary of operation
// - Host times setup to last strobe active, hold from first inactive.
// - Host keeps select or strobe inactive while address lines change.
// - Host keeps write strobe high throughout every read.
// - Host makes address valid no later than select going active.
// - Read: address, select and output gate low, strobe high, data appears.
module asc_host #(
    parameter int ADDR_W = asc_pkg::ADDR_W,
    parameter int DATA_W = asc_pkg::DATA_W
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // User request port
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic [DATA_W-1:0] REQ_WDATA,
    // User answer port
    output logic RSP_VALID,
    output logic [DATA_W-1:0] RSP_RDATA,
    // RAM pins
    output logic [ADDR_W-1:0] WORD_SELECT_LINES,
    output logic CHIP_SEL_B,
    output logic WRITE_STROBE_B,
    output logic OUT_GATE_B,
    input wire logic [DATA_W-1:0] SHARED_DATA_PINS_I,
    output logic [DATA_W-1:0] SHARED_DATA_PINS_O,
    output logic SHARED_DATA_PINS_OE
);
    // ----------------------------------------
    // Timer
    // ----------------------------------------
    asc_tick_if tk ();
    asc_timer u_timer (
        .CLK(CLK),
        .RST_B(RST_B),
        .tk(tk)
    );
    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    asc_pkg::asc_state_e state_r;
    asc_pkg::asc_state_e state_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] rdata_r;
    logic cs_b_r;
    logic we_b_r;
    logic oe_b_r;
    logic doe_r;
    logic rsp_r;
    logic take;
    logic rd_done;
    logic [asc_pkg::CNT_W-1:0] load_cnt;

    assign REQ_READY = (state_r == asc_pkg::ASC_IDLE);
    assign take = REQ_VALID && REQ_READY;
    assign rd_done = (state_r == asc_pkg::ASC_RD_WAIT) && tk.done;

    // Timer load on each state entry that waits.
    assign tk.load = take || (state_r == asc_pkg::ASC_RD_SEL) || (state_r == asc_pkg::ASC_WR_SEL)
        || rd_done || ((state_r == asc_pkg::ASC_WR_PULSE) && tk.done);
    assign load_cnt = (state_r == asc_pkg::ASC_WR_SEL) ? asc_pkg::CNT_W'(asc_pkg::WRITE_CYC - 1)
        : (state_r == asc_pkg::ASC_RD_SEL) ? asc_pkg::CNT_W'(asc_pkg::ACCESS_CYC)
        : (rd_done ? asc_pkg::CNT_W'(asc_pkg::OFF_CYC - 1) : asc_pkg::CNT_ZERO);
    assign tk.count = load_cnt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            asc_pkg::ASC_IDLE: begin
                if (take) begin
                    state_nxt = REQ_WRITE ? asc_pkg::ASC_WR_SEL : asc_pkg::ASC_RD_SEL;
                end
            end
            asc_pkg::ASC_RD_SEL: begin
                state_nxt = asc_pkg::ASC_RD_WAIT;
            end
            asc_pkg::ASC_RD_WAIT: begin
                if (tk.done) begin
                    state_nxt = asc_pkg::ASC_RECOVER;
                end
            end
            asc_pkg::ASC_WR_SEL: begin
                state_nxt = asc_pkg::ASC_WR_PULSE;
            end
            asc_pkg::ASC_WR_PULSE: begin
                if (tk.done) begin
                    state_nxt = asc_pkg::ASC_RECOVER;
                end
            end
            asc_pkg::ASC_RECOVER: begin
                if (tk.done) begin
                    state_nxt = asc_pkg::ASC_IDLE;
                end
            end
            default: begin
                state_nxt = asc_pkg::ASC_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Address and data are latched on the same edge on which select and the write strobe or output gate go active.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            addr_r <= '0;
            wdata_r <= '0;
        end else if (take) begin
            addr_r <= REQ_ADDR;
            wdata_r <= REQ_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= asc_pkg::ASC_IDLE;
            cs_b_r <= 1'b1;
            we_b_r <= 1'b1;
            oe_b_r <= 1'b1;
            doe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            // Select asserts on the same edge that latches the address; drops before it changes.
            cs_b_r <= !(state_nxt == asc_pkg::ASC_RD_WAIT || state_nxt == asc_pkg::ASC_WR_PULSE
                || state_nxt == asc_pkg::ASC_RD_SEL || state_nxt == asc_pkg::ASC_WR_SEL);
            // Strobe falls with select so the RAM never drives; it rises with select at the end.
            we_b_r <= !(state_nxt == asc_pkg::ASC_WR_SEL || state_nxt == asc_pkg::ASC_WR_PULSE);
            oe_b_r <= !(state_nxt == asc_pkg::ASC_RD_SEL || state_nxt == asc_pkg::ASC_RD_WAIT);
            // Host drives the bus only while the strobe holds the RAM outputs off.
            doe_r <= (state_nxt == asc_pkg::ASC_WR_SEL || state_nxt == asc_pkg::ASC_WR_PULSE);
        end
    end

    // Read data is sampled at the end of the access wait, before select is dropped.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_r <= '0;
            rsp_r <= 1'b0;
        end else begin
            rsp_r <= rd_done || ((state_r == asc_pkg::ASC_WR_PULSE) && tk.done);
            if (rd_done) begin
                rdata_r <= SHARED_DATA_PINS_I;
            end
        end
    end

    assign WORD_SELECT_LINES = addr_r;
    assign CHIP_SEL_B = cs_b_r;
    assign WRITE_STROBE_B = we_b_r;
    assign OUT_GATE_B = oe_b_r;
    assign SHARED_DATA_PINS_O = wdata_r;
    assign SHARED_DATA_PINS_OE = doe_r;
    assign RSP_VALID = rsp_r;
    assign RSP_RDATA = rdata_r;
endmodule : asc_host

/* File: verif/asc_host_sva.sv */
// Checker of the RAM pin sequencing of the SRAM host controller.
// Assumes it is bound to asc_host and sees only its ports.
`timescale 1ns/100ps
module asc_host_sva (
    // Watched ports
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic RSP_VALID,
    input wire logic [14:0] WORD_SELECT_LINES,
    input wire logic CHIP_SEL_B,
    input wire logic WRITE_STROBE_B,
    input wire logic OUT_GATE_B,
    input wire logic [7:0] SHARED_DATA_PINS_O,
    input wire logic SHARED_DATA_PINS_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_read_strobe_high: assert property (!OUT_GATE_B |-> WRITE_STROBE_B) else $error("strobe low in read");
    a_addr_when_off: assert property (!$stable(WORD_SELECT_LINES) |-> $past(CHIP_SEL_B))
        else $error("addr moved");
    a_wdata_held: assert property (!WRITE_STROBE_B |=> WRITE_STROBE_B || $stable(SHARED_DATA_PINS_O))
        else $error("write data moved");
    a_write_drive: assert property (!WRITE_STROBE_B |-> SHARED_DATA_PINS_OE && OUT_GATE_B)
        else $error("write drive");
    a_strobe_fall_sel: assert property ($fell(WRITE_STROBE_B) |-> $fell(CHIP_SEL_B))
        else $error("strobe fall");
    a_strobe_rise_sel: assert property ($rose(WRITE_STROBE_B) |-> CHIP_SEL_B) else $error("strobe rise");
    a_no_fight: assert property (!OUT_GATE_B |-> !SHARED_DATA_PINS_OE) else $error("pin fight");
    a_read_answer: assert property ($fell(OUT_GATE_B) |-> ##4 RSP_VALID) else $error("read answer");
    a_write_answer: assert property ($fell(WRITE_STROBE_B) |-> ##3 RSP_VALID) else $error("write answer");
endmodule : asc_host_sva

/* File: verif/asc_sram_model.sv */
// Behavioural model of the asynchronous 32K x 8 static RAM.
// Assumes the bench resolves the shared data pins from both enables.
`timescale 1ns/100ps
module asc_sram_model #(
    parameter int PD_NS = 35
) (
    // Host pins
    input wire logic [14:0] a,
    input wire logic cs_b,
    input wire logic we_b,
    input wire logic oe_b,
    input wire logic [7:0] d,
    output logic [7:0] q,
    output logic q_en,
    // Power state
    output logic active_power_state
);
    logic [7:0] mem [0:32767];
    always @(cs_b, we_b, a, d) begin
        if (!cs_b && !we_b) begin
            mem[a] = d;
        end
    end
    assign q = mem[a];
    assign q_en = !cs_b && !oe_b && we_b;
    initial active_power_state = 1'b0;
    always begin
        @(negedge cs_b, negedge we_b, a, d);
        if (!cs_b) begin
            active_power_state = 1'b1;
            #(PD_NS) active_power_state = 1'b0;
        end
    end
endmodule : asc_sram_model

/* File: verif/asc_host_tb.sv */
// Self-checking bench of the SRAM host controller.
// Assumes the package, interface, design and model files are compiled first.
`timescale 1ns/100ps
module asc_host_tb;
    logic CLK, RST_B, REQ_VALID, REQ_WRITE;
    logic [14:0] REQ_ADDR;
    logic [7:0] REQ_WDATA, q;
    logic [7:0] last_r = 8'h00;
    logic REQ_READY, RSP_VALID, CHIP_SEL_B, WRITE_STROBE_B, OUT_GATE_B, SHARED_DATA_PINS_OE, q_en, awake;
    logic [7:0] RSP_RDATA, SHARED_DATA_PINS_O;
    logic [14:0] WORD_SELECT_LINES;
    wire logic [7:0] pins_i;
    int err_count = 0;
    int cmp_count = 0;
    // Rows hold write flag, address and data; read rows hold the expected data.
    logic [23:0] rows [0:5] = '{24'h800055, 24'hFFFFAA, 24'h000055, 24'h7FFFAA, 24'h800101, 24'h000101};
    // A released bus shows the inverse of its last level.
    assign pins_i = SHARED_DATA_PINS_OE ? SHARED_DATA_PINS_O : (q_en ? q : ~last_r);
    always @(posedge CLK) last_r <= pins_i;
    asc_host dut (.CLK, .RST_B, .REQ_VALID, .REQ_READY, .REQ_WRITE, .REQ_ADDR, .REQ_WDATA, .RSP_VALID, .RSP_RDATA,
        .WORD_SELECT_LINES, .CHIP_SEL_B, .WRITE_STROBE_B, .OUT_GATE_B, .SHARED_DATA_PINS_I(pins_i),
        .SHARED_DATA_PINS_O, .SHARED_DATA_PINS_OE);
    asc_sram_model ram (.a(WORD_SELECT_LINES), .cs_b(CHIP_SEL_B), .we_b(WRITE_STROBE_B), .oe_b(OUT_GATE_B),
        .d(pins_i), .q, .q_en, .active_power_state(awake));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic [23:0] row);
        int n;
        n = 0;
        {REQ_WRITE, REQ_ADDR, REQ_WDATA} = row;
        REQ_VALID = 1'b1;
        while (REQ_READY !== 1'b1 && n < 20) begin
            @(posedge CLK);
            #1 n++;
        end
        @(posedge CLK);
        #1 REQ_VALID = 1'b0;
        chk("wake", 8'h01, {7'h00, awake});
        n = 0;
        while (RSP_VALID !== 1'b1 && n < 20) begin
            @(posedge CLK);
            #1 n++;
        end
        chk("latency", row[23] ? 8'h03 : 8'h04, n[7:0]);
        if (!row[23]) chk("rdata", row[7:0], RSP_RDATA);
    endtask : xfer
    task automatic end_of_test();
        $display("Compares %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    initial begin
        #20000 err_count++;
        end_of_test();
    end
    initial begin
        {RST_B, REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_WDATA} = '0;
        repeat (20) @(posedge CLK);
        #1 RST_B = 1'b1;
        foreach (rows[i]) xfer(rows[i]);
        repeat (10) @(posedge CLK);
        #1 chk("awake", 8'h00, {7'h00, awake});
        xfer(24'h000055);
        // Reset in mid-write rewrites the same byte, so the read-back is known.
        {REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_WDATA} = 25'h1800101;
        repeat (2) @(posedge CLK);
        #1 chk("strobe", 8'h00, {7'h00, WRITE_STROBE_B});
        RST_B = 1'b0;
        REQ_VALID = 1'b0;
        #1 chk("idle pins", 8'h1E,
            {3'h0, REQ_READY, CHIP_SEL_B, WRITE_STROBE_B, OUT_GATE_B, SHARED_DATA_PINS_OE});
        repeat (2) @(posedge CLK);
        #1 RST_B = 1'b1;
        xfer(24'h000101);
        end_of_test();
    end
endmodule : asc_host_tb
bind asc_host asc_host_sva sva (.CLK, .RST_B, .RSP_VALID, .WORD_SELECT_LINES, .CHIP_SEL_B, .WRITE_STROBE_B,
    .OUT_GATE_B, .SHARED_DATA_PINS_O, .SHARED_DATA_PINS_OE);
